// file: core/bgd_pkg.sv
package bgd_pkg;
	localparam int SEG_N = 20;
	localparam int PW_W = 10;
	localparam int FQ_W = 16;
	localparam int AW = 5;
	localparam int CLK_HZ = 20_000_000;
	localparam int BLINK_MS = 500;
	localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int BLINK_CW = 24;
	// Power in per-mille: 50 = 5 %, 1000 = full rated output
	localparam logic [PW_W-1:0] PM_STEP = 10'h032;
	localparam logic [PW_W-1:0] PM_FULL = 10'h3E8;
	// Frequency bin origin (lower edge of segment 1) and width, Hz
	localparam logic [FQ_W-1:0] F20_BASE = 16'h4C13;
	localparam logic [7:0] F20_WIDTH = 8'h32;
	localparam logic [FQ_W-1:0] F30_BASE = 16'h725E;
	localparam logic [7:0] F30_WIDTH = 8'h4C;
	localparam logic [FQ_W-1:0] F40_BASE = 16'h9826;
	localparam logic [7:0] F40_WIDTH = 8'h64;
	localparam logic [SEG_N-1:0] SEG_HALF = 20'h0_0200;
	// Register byte offsets
	localparam logic [AW-1:0] REG_CTRL = 5'h00;
	localparam logic [AW-1:0] REG_STATUS = 5'h04;
	localparam logic [AW-1:0] REG_PEAK = 5'h08;
	localparam logic [AW-1:0] REG_FREQ = 5'h0C;
	localparam logic [AW-1:0] REG_SEGS = 5'h10;
	localparam logic [AW-1:0] REG_POWER = 5'h14;

	typedef enum logic [1:0] {VAR_20K, VAR_30K, VAR_40K, VAR_RSVD} bgd_var_e;

	typedef struct packed {
		bgd_var_e variant;
		logic store_en;
		logic disp_freq;
	} bgd_ctrl_s;

	localparam bgd_ctrl_s CTRL_RST = '{variant: VAR_20K, store_en: 1'b1,
		disp_freq: 1'b0};

	typedef enum logic [1:0] {ST_IDLE, ST_TEST, ST_ALARM} bgd_state_e;

	function automatic logic [SEG_N-1:0] therm(input logic [PW_W-1:0] pm);
		logic [SEG_N-1:0] b;
		b = '0;
		for (int k = 0; k < SEG_N; k++) begin
			b[k] = ({1'b0, pm} >= 11'(PM_STEP) * 11'(k + 1));
		end
		return b;
	endfunction : therm
endpackage : bgd_pkg

// file: core/bgd_freq_bin.sv
`timescale 1ns/10ps
`default_nettype none
module bgd_freq_bin (
	// Stored frequency and unit variant
	input wire logic [bgd_pkg::FQ_W-1:0] freq,
	input wire bgd_pkg::bgd_var_e variant,
	// One-hot segment
	output logic [bgd_pkg::SEG_N-1:0] seg
);
	logic [bgd_pkg::FQ_W-1:0] base;
	logic [7:0] width;
	logic [bgd_pkg::SEG_N-1:0] above;
	logic [4:0] idx;

	always_comb begin
		case (variant)
			bgd_pkg::VAR_30K: begin
				base = bgd_pkg::F30_BASE;
				width = bgd_pkg::F30_WIDTH;
			end
			bgd_pkg::VAR_40K: begin
				base = bgd_pkg::F40_BASE;
				width = bgd_pkg::F40_WIDTH;
			end
			default: begin
				base = bgd_pkg::F20_BASE;
				width = bgd_pkg::F20_WIDTH;
			end
		endcase
	end

	// Threshold k is the lower edge of segment k+1
	assign above[0] = 1'b0;
	genvar k;
	generate
		for (k = 1; k < bgd_pkg::SEG_N; k++) begin : g_th
			assign above[k] = {1'b0, freq} >=
				(17'(base) + 17'(width) * 17'(k));
		end
	endgenerate

	// Out-of-range values clamp to the end segments
	always_comb begin
		idx = '0;
		for (int i = 1; i < bgd_pkg::SEG_N; i++) begin
			idx = idx + 5'(above[i]);
		end
		seg = '0;
		seg[idx] = 1'b1;
	end
endmodule : bgd_freq_bin
`default_nettype wire

// file: core/bgd_bargraph.sv
`timescale 1ns/10ps
`default_nettype none
module bgd_bargraph #(
	parameter int BLINK_CYC = bgd_pkg::BLINK_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [bgd_pkg::AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Front panel and system inputs
	input wire logic manual_mode,
	input wire logic test_key,
	input wire logic alarm_reset_key,
	input wire logic weld_req,
	input wire logic overload,
	input wire logic mem_reset,
	input wire logic [bgd_pkg::PW_W-1:0] power_in,
	input wire logic [bgd_pkg::FQ_W-1:0] freq_in,
	// Generator control
	output logic sonics_run,
	output logic tune_en,
	// Display
	output logic [bgd_pkg::SEG_N-1:0] seg,
	output logic power_ind,
	output logic sonics_ind,
	output logic alarm_ind
);
	localparam logic [bgd_pkg::BLINK_CW-1:0] BLINK_LAST =
		bgd_pkg::BLINK_CW'(BLINK_CYC - 1);
	// Exclusive upper edge of segment 20 for each variant
	localparam logic [bgd_pkg::FQ_W-1:0] F20_TOP =
		bgd_pkg::F20_BASE + bgd_pkg::FQ_W'(bgd_pkg::SEG_N) *
		bgd_pkg::FQ_W'(bgd_pkg::F20_WIDTH);
	localparam logic [bgd_pkg::FQ_W-1:0] F30_TOP =
		bgd_pkg::F30_BASE + bgd_pkg::FQ_W'(bgd_pkg::SEG_N) *
		bgd_pkg::FQ_W'(bgd_pkg::F30_WIDTH);
	localparam logic [bgd_pkg::FQ_W-1:0] F40_TOP =
		bgd_pkg::F40_BASE + bgd_pkg::FQ_W'(bgd_pkg::SEG_N) *
		bgd_pkg::FQ_W'(bgd_pkg::F40_WIDTH);

	// Bus group
	logic ack, next_ack;
	logic [31:0] next_readdata;
	bgd_pkg::bgd_ctrl_s ctrl, next_ctrl;
	// Run group
	bgd_pkg::bgd_state_e state, next_state;
	logic run_d, next_run_d;
	logic blink, next_blink;
	logic [bgd_pkg::PW_W-1:0] peak, next_peak;
	logic [bgd_pkg::FQ_W-1:0] freq_store, next_freq_store;
	// Display group
	logic [bgd_pkg::SEG_N-1:0] next_seg;
	logic next_power_ind;
	logic [bgd_pkg::BLINK_CW-1:0] bcnt, next_bcnt;
	logic phase, next_phase;

	logic running, cyc_start, cyc_end, key_ok, rst_key;
	logic [bgd_pkg::SEG_N-1:0] freq_seg;
	logic freq_shown;

	assign running = weld_req || (state == bgd_pkg::ST_TEST);
	assign cyc_start = running && !run_d;
	assign cyc_end = !running && run_d;
	// Idle frequency bar goes to the glass on the next edge
	assign freq_shown = !running && !blink && ctrl.disp_freq;
	assign key_ok = manual_mode;
	assign rst_key = key_ok && alarm_reset_key;
	assign sonics_run = running;
	// Drive follows measured resonance only during a test
	assign tune_en = (state == bgd_pkg::ST_TEST);
	assign alarm_ind = (state == bgd_pkg::ST_ALARM);
	assign sonics_ind = power_ind;
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	bgd_freq_bin u_bin (
		.freq(freq_store),
		.variant(ctrl.variant),
		.seg(freq_seg)
	);

	// Register bus: one wait state, then the answer
	always_comb begin
		next_ack = (avs_read || avs_write) && !ack;
		next_ctrl = ctrl;
		next_readdata = avs_readdata;
		if (avs_write && ack && avs_address == bgd_pkg::REG_CTRL) begin
			next_ctrl = bgd_pkg::bgd_ctrl_s'(avs_writedata[3:0]);
		end
		if (avs_read && !ack) begin
			next_readdata = '0;
			case (avs_address)
				bgd_pkg::REG_CTRL: next_readdata[3:0] = ctrl;
				bgd_pkg::REG_STATUS: next_readdata[4:0] = {tune_en, manual_mode,
					blink, alarm_ind, running};
				bgd_pkg::REG_PEAK: next_readdata[bgd_pkg::PW_W-1:0] = peak;
				bgd_pkg::REG_FREQ: next_readdata[bgd_pkg::FQ_W-1:0] = freq_store;
				bgd_pkg::REG_SEGS: next_readdata[bgd_pkg::SEG_N-1:0] = seg;
				bgd_pkg::REG_POWER: next_readdata[bgd_pkg::PW_W-1:0] = power_in;
				default: next_readdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ack <= 1'b0;
			ctrl <= bgd_pkg::CTRL_RST;
			avs_readdata <= '0;
		end else begin
			ack <= next_ack;
			ctrl <= next_ctrl;
			avs_readdata <= next_readdata;
		end
	end

	// Test sequencing, peak and frequency capture
	always_comb begin
		next_state = state;
		next_run_d = running;
		next_blink = blink;
		next_peak = peak;
		next_freq_store = freq_store;
		case (state)
			bgd_pkg::ST_IDLE: begin
				if (key_ok && test_key) begin
					next_state = bgd_pkg::ST_TEST;
				end
			end
			bgd_pkg::ST_TEST: begin
				if (overload) begin
					next_state = bgd_pkg::ST_ALARM;
				end else if (!test_key || !key_ok) begin
					next_state = bgd_pkg::ST_IDLE;
				end
			end
			bgd_pkg::ST_ALARM: begin
				if (rst_key) begin
					next_state = bgd_pkg::ST_IDLE;
				end
			end
			default: next_state = bgd_pkg::ST_IDLE;
		endcase
		// Clear first so a coincident event still sets
		if (rst_key || cyc_start) begin
			next_blink = 1'b0;
		end
		if (mem_reset || (overload && state == bgd_pkg::ST_TEST)) begin
			next_blink = 1'b1;
		end
		if (cyc_start) begin
			next_peak = power_in;
		end else if (running && power_in > peak) begin
			next_peak = power_in;
		end
		if (cyc_end && ctrl.store_en) begin
			next_freq_store = freq_in;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= bgd_pkg::ST_IDLE;
			run_d <= 1'b0;
			blink <= 1'b0;
			peak <= '0;
			freq_store <= '0;
		end else begin
			state <= next_state;
			run_d <= next_run_d;
			blink <= next_blink;
			peak <= next_peak;
			freq_store <= next_freq_store;
		end
	end

	// Display selection and blink timing
	always_comb begin
		next_bcnt = bcnt + 1'b1;
		next_phase = phase;
		if (!blink) begin
			next_bcnt = '0;
			next_phase = 1'b1;
		end else if (bcnt == BLINK_LAST) begin
			next_bcnt = '0;
			next_phase = !phase;
		end
		next_power_ind = running;
		if (running) begin
			// Thresholds stop at 100 percent, so overrange cannot add bars
			next_seg = bgd_pkg::therm(power_in);
		end else if (blink) begin
			next_seg = phase ? bgd_pkg::SEG_HALF : '0;
		end else if (ctrl.disp_freq) begin
			next_seg = freq_seg;
		end else begin
			next_seg = bgd_pkg::therm(peak);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			seg <= '0;
			power_ind <= 1'b0;
			bcnt <= '0;
			phase <= 1'b1;
		end else begin
			seg <= next_seg;
			power_ind <= next_power_ind;
			bcnt <= next_bcnt;
			phase <= next_phase;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	chk_bolt_follows_run: assert property (
		running |=> power_ind && sonics_ind)
		else $error("running indicator did not follow sonics");
	chk_live_bar_count: assert property (
		running |=> $countones(seg) == (($past(power_in) >= 10'h3E8) ? 20 :
			int'($past(power_in)) / 50))
		else $error("live bar count wrong");
	chk_bar_contiguous: assert property (
		running |=> ((seg & (seg + 20'h0_0001)) == '0))
		else $error("power bar not filled from the bottom");
	chk_below_first_step: assert property (
		running && power_in < 10'h032 |=> seg == '0)
		else $error("segment lit below 5 percent");
	chk_full_scale: assert property (
		running && power_in >= 10'h3E8 |=> &seg)
		else $error("full power did not light all segments");
	chk_freq_one_bar: assert property (
		!running && !blink && ctrl.disp_freq |=> $onehot(seg))
		else $error("frequency display not a single bar");
	chk_blink_half_only: assert property (
		!running && blink |=> (seg & ~20'h0_0200) == '0)
		else $error("blink shows other than the half segment");
	chk_auto_ignored: assert property (
		state == bgd_pkg::ST_IDLE && !manual_mode |=>
			state != bgd_pkg::ST_TEST)
		else $error("test started outside manual mode");
	chk_key_release: assert property (
		state == bgd_pkg::ST_TEST && !test_key |=> !tune_en)
		else $error("test kept running after key release");
	chk_alarm_holds: assert property (
		alarm_ind && !(manual_mode && alarm_reset_key) |=> alarm_ind)
		else $error("alarm dropped without reset key");
	chk_freq_capture: assert property (
		cyc_end && ctrl.store_en |=> freq_store == $past(freq_in))
		else $error("frequency not stored at cycle end");
	chk_overload_alarm: assert property (
		state == bgd_pkg::ST_TEST && overload |=> blink && alarm_ind)
		else $error("overload did not raise alarm and blink");
	chk_tune_on_test: assert property (
		state == bgd_pkg::ST_IDLE && key_ok && test_key |=>
			tune_en && sonics_run)
		else $error("test start did not enable tuning");
	chk_peak_restart: assert property (
		cyc_start |=> peak == $past(power_in))
		else $error("peak not restarted at cycle start");
	chk_peak_bars: assert property (
		!running && !blink && !ctrl.disp_freq |=>
			$countones(seg) == (($past(peak) >= bgd_pkg::PM_FULL) ?
			bgd_pkg::SEG_N : int'($past(peak)) / int'(bgd_pkg::PM_STEP)))
		else $error("peak bar count wrong");
	chk_memreset_blink: assert property (
		mem_reset |=> blink)
		else $error("memory reset did not start blinking");
	chk_latch_off_hold: assert property (
		!ctrl.store_en |=> $stable(freq_store))
		else $error("stored frequency changed with latch off");
	chk_low_clamp: assert property (
		freq_shown && freq_store < bgd_pkg::F20_BASE |=>
			seg == 20'h0_0001)
		else $error("low frequency not clamped to first segment");
	chk_high_clamp: assert property (
		freq_shown && freq_store >= F40_TOP |=> seg == 20'h8_0000)
		else $error("high frequency not clamped to last segment");
	chk_bin_20k: assert property (
		freq_shown && ctrl.variant == bgd_pkg::VAR_20K &&
			freq_store >= bgd_pkg::F20_BASE && freq_store < F20_TOP |=>
			seg == (20'h0_0001 << (($past(freq_store) -
			bgd_pkg::F20_BASE) / bgd_pkg::F20_WIDTH)))
		else $error("20 kHz frequency bin wrong");
	chk_bin_30k: assert property (
		freq_shown && ctrl.variant == bgd_pkg::VAR_30K &&
			freq_store >= bgd_pkg::F30_BASE && freq_store < F30_TOP |=>
			seg == (20'h0_0001 << (($past(freq_store) -
			bgd_pkg::F30_BASE) / bgd_pkg::F30_WIDTH)))
		else $error("30 kHz frequency bin wrong");
	chk_bin_40k: assert property (
		freq_shown && ctrl.variant == bgd_pkg::VAR_40K &&
			freq_store >= bgd_pkg::F40_BASE && freq_store < F40_TOP |=>
			seg == (20'h0_0001 << (($past(freq_store) -
			bgd_pkg::F40_BASE) / bgd_pkg::F40_WIDTH)))
		else $error("40 kHz frequency bin wrong");
endmodule : bgd_bargraph
`default_nettype wire

// file: testbench/bgd_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
module bgd_panel_model (
	// Clock
	input wire logic ref_clk,
	// Glass
	input wire logic [19:0] seg,
	// What the operator sees
	output logic [4:0] lit_n
);
	// Glass latches once per clock, so a count lags the bars by one edge
	always_ff @(posedge ref_clk) begin
		lit_n <= 5'($countones(seg));
	end
endmodule : bgd_panel_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic [31:0] rd;
	logic avs_waitrequest, sonics_run, tune_en, power_ind, sonics_ind;
	logic alarm_ind;
	logic manual_mode = 1'b1;
	logic test_key = 1'b0;
	logic alarm_reset_key = 1'b0;
	logic weld_req = 1'b0;
	logic overload = 1'b0;
	logic mem_reset = 1'b0;
	logic [9:0] power_in = '0;
	logic [15:0] freq_in = '0;
	logic [19:0] seg;
	logic [4:0] lit_n;
	int errors = 0;
	int compares = 0;

	always #25 ref_clk = ~ref_clk;

	bgd_bargraph #(.BLINK_CYC(8)) bgd_bargraph_inst (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .manual_mode(manual_mode),
		.test_key(test_key), .alarm_reset_key(alarm_reset_key),
		.weld_req(weld_req), .overload(overload), .mem_reset(mem_reset),
		.power_in(power_in), .freq_in(freq_in), .sonics_run(sonics_run),
		.tune_en(tune_en), .seg(seg), .power_ind(power_ind),
		.sonics_ind(sonics_ind), .alarm_ind(alarm_ind)
	);
	bgd_panel_model bgd_panel_model_inst (
		.ref_clk(ref_clk), .seg(seg), .lit_n(lit_n)
	);

	task results;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check

	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (i == 20) begin
			errors++;
			results;
		end
	endtask : bus

	function automatic logic [19:0] bars(input int p);
		return p >= 1000 ? 20'hF_FFFF : (20'h0_0001 << (p / 50)) - 20'h0_0001;
	endfunction : bars

	task key(input logic v);
		@(posedge ref_clk) test_key <= v;
		tick(4);
	endtask : key

	task sc_reset;
		check("seg", seg, 32'h0000_0000);
		check("alarm", alarm_ind, 32'h0000_0000);
		bus(1'b0, bgd_pkg::REG_CTRL, 32'h0000_0000);
		check("ctrl", rd, 32'h0000_0002);
		bus(1'b0, 5'h1C, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
	endtask : sc_reset

	task sc_power;
		int p [7] = '{0, 49, 50, 300, 999, 1000, 1023};
		key(1'b1);
		check("tune", tune_en, 32'h0000_0001);
		check("sonics", sonics_ind, 32'h0000_0001);
		foreach (p[i]) begin
			@(posedge ref_clk) power_in <= 10'(p[i]);
			tick(3);
			check("bars", seg, bars(p[i]));
			check("bolt", power_ind, 32'h0000_0001);
		end
		key(1'b0);
		// Second cycle: peak must restart, not carry the old full scale
		@(posedge ref_clk) power_in <= 10'd300;
		key(1'b1);
		@(posedge ref_clk) power_in <= 10'd150;
		key(1'b0);
		check("peak", seg, bars(300));
		check("stop", sonics_run, 32'h0000_0000);
		bus(1'b0, bgd_pkg::REG_PEAK, 32'h0000_0000);
		check("peakreg", rd, 32'h0000_012C);
	endtask : sc_power

	task sc_manual;
		@(posedge ref_clk) manual_mode <= 1'b0;
		key(1'b1);
		check("nomanual", {tune_en, sonics_run}, 32'h0000_0000);
		key(1'b0);
		// Automation weld runs sonics whatever the panel mode
		@(posedge ref_clk) weld_req <= 1'b1;
		tick(3);
		check("weld", {sonics_run, power_ind}, 32'h0000_0003);
		check("weldbar", seg, bars(150));
		@(posedge ref_clk) weld_req <= 1'b0;
		tick(3);
		check("weldpeak", seg, bars(150));
		@(posedge ref_clk) manual_mode <= 1'b1;
	endtask : sc_manual

	task sc_freq(input logic [31:0] c, input int f, input int s);
		bus(1'b1, bgd_pkg::REG_CTRL, c);
		@(posedge ref_clk) freq_in <= 16'(f);
		key(1'b1);
		key(1'b0);
		check("fbin", seg, 20'h0_0001 << (s - 1));
		check("lit", lit_n, 32'h0000_0001);
	endtask : sc_freq

	task blink;
		int on = 0;
		int off = 0;
		int bad = 0;
		repeat (24) begin
			@(posedge ref_clk);
			if (seg === bgd_pkg::SEG_HALF)
				on++;
			else if (seg === 20'h0_0000)
				off++;
			else
				bad++;
		end
		check("blink", {on > 0, off > 0, bad == 0}, 32'h0000_0007);
	endtask : blink

	task sc_alarm;
		key(1'b1);
		@(posedge ref_clk) overload <= 1'b1;
		@(posedge ref_clk) overload <= 1'b0;
		tick(2);
		check("alarm", {alarm_ind, sonics_run}, 32'h0000_0002);
		blink;
		key(1'b0);
		key(1'b1);
		check("locked", {alarm_ind, sonics_run}, 32'h0000_0002);
		bus(1'b0, bgd_pkg::REG_STATUS, 32'h0000_0000);
		check("status", rd, 32'h0000_000E);
		key(1'b0);
		@(posedge ref_clk) alarm_reset_key <= 1'b1;
		@(posedge ref_clk) alarm_reset_key <= 1'b0;
		tick(2);
		check("cleared", alarm_ind, 32'h0000_0000);
		@(posedge ref_clk) mem_reset <= 1'b1;
		@(posedge ref_clk) mem_reset <= 1'b0;
		// The glass picks up the blink one edge after the flag
		tick(1);
		blink;
	endtask : sc_alarm

	task sc_rerun;
		@(posedge ref_clk) sys_rst <= 1'b1;
		tick(2);
		sys_rst <= 1'b0;
		sc_reset;
	endtask : sc_rerun

	initial begin
		tick(16);
		sys_rst <= 1'b0;
		sc_reset;
		sc_power;
		sc_manual;
		sc_freq(32'h0000_0003, 19975, 11);
		sc_freq(32'h0000_0003, 19775, 7);
		sc_freq(32'h0000_0003, 100, 1);
		sc_freq(32'h0000_0003, 65000, 20);
		sc_freq(32'h0000_0007, 29278, 1);
		sc_freq(32'h0000_0007, 30797, 20);
		sc_freq(32'h0000_000F, 19975, 11);
		sc_freq(32'h0000_000B, 40000, 11);
		// Latch off: the previous stored bin must survive
		sc_freq(32'h0000_0009, 39000, 11);
		sc_alarm;
		sc_rerun;
		results;
	end
endmodule : testbench
`default_nettype wire
